// file: rtl/math_unit_defs.svh
/*
  Constants for the four-operand math unit: register offsets, field positions,
  reset values and saturation limits.
  Assumes inclusion by bare name from the design module only.
*/
`ifndef MATH_UNIT_DEFS_SVH
`define MATH_UNIT_DEFS_SVH

`define OFS_CTRL 12'h000
`define OFS_OPSEL 12'h004
`define OFS_OPS 12'h008
`define OFS_PRIO 12'h00C
`define OFS_CONST0 12'h010
`define OFS_CONST1 12'h014
`define OFS_CONST2 12'h018
`define OFS_CONST3 12'h01C
`define OFS_RESULT 12'h020
`define OFS_STATUS 12'h024
`define OFS_IRQ_STAT 12'h028
`define OFS_IRQ_MASK 12'h02C

`define CTRL_HOLD_BIT 0
`define CTRL_DEC_LSB 1
`define CTRL_RESET 32'h0000_0000
`define OPS_RESET 6'h00
`define PRIO_RESET 6'h24
`define SAT_MAX 16'sh7FFF
`define SAT_MIN 16'sh8000
`define IRQ_BITS 2

`endif

// file: rtl/math_unit_pkg.sv
/*
  Types for the four-operand math unit.
  Needs nothing from math_unit_defs.svh; only the design module includes it.
*/
package math_unit_pkg;

  typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_MUL, OP_DIV} op_type;

  typedef enum logic [1:0] {PRI_LOW, PRI_MED, PRI_HIGH, PRI_NONE} prio_type;

  typedef struct packed {
    logic zero_div;
    logic overflow;
  } err_type;

  typedef struct packed {
    logic signed [15:0] value;
    err_type err;
  } result_type;

endpackage : math_unit_pkg

// file: rtl/four_operand_math_unit.sv
/*
  Four-operand math unit with AXI4-Lite register slave and interrupt.
  Assumes a 40 MHz mclk, synchronous srst, operand links from logic on the
  same clock, and a master that keeps at most one read and one write open.
*/
// Operation
// - four operands, three add/sub/mul/div operators
// - evaluate high, then medium, then low
// - round final result to nearest integer
// - zero divide or overflow saturates 32767
// - negative underflow saturates to -32768
// - compute only while enable asserted
// - disabled: hold output or drive zero
// - keep separate zero-divide and overflow flags
// - each operand constant or linked block output
// - decimal places 0-3, display only
// - flags rewritten every evaluation, one or zero
`include "math_unit_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module four_operand_math_unit (
  input wire logic mclk,
  input wire logic srst,
  input wire logic enable,
  input wire logic signed [15:0] link_operand [4],
  output logic signed [15:0] math_result,
  output logic zero_div_flag,
  output logic overflow_flag,
  output logic irq,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // 64 bits: a product of two products still cannot wrap
  typedef logic signed [63:0] wide_type;
  logic [31:0] ctrl_ff;
  logic [3:0] opsel_ff;
  logic [5:0] ops_ff;
  logic [5:0] prio_ff;
  logic signed [15:0] const_ff [4];
  logic signed [15:0] result_ff;
  logic zdiv_ff;
  logic ovf_ff;
  logic [`IRQ_BITS-1:0] irq_stat_ff;
  logic [`IRQ_BITS-1:0] irq_mask_ff;
  // operand source select
  wire signed [15:0] opnd [4];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sel
      assign opnd[gi] = opsel_ff[gi] ? link_operand[gi] : const_ff[gi];
    end
  endgenerate
  // one operation on wide values; final-step division rounds half away from zero
  function automatic wide_type apply_op(input math_unit_pkg::op_type op,
                                        input wide_type a, input wide_type b,
                                        input logic last);
    wide_type q;
    wide_type r;
    wide_type ar;
    wide_type ab;
    unique case (op)
      math_unit_pkg::OP_ADD: apply_op = a + b;
      math_unit_pkg::OP_SUB: apply_op = a - b;
      math_unit_pkg::OP_MUL: apply_op = 64'(a * b);
      math_unit_pkg::OP_DIV:
      begin
        if (b == 0)
          apply_op = '0;
        else
        begin
          q = a / b;
          r = a % b;
          ar = (r < 0) ? -r : r;
          ab = (b < 0) ? -b : b;
          // only the final step rounds; earlier steps truncate like integers
          if (last && (ar + ar >= ab))
            apply_op = ((a < 0) != (b < 0)) ? q - 64'sd1 : q + 64'sd1;
          else
            apply_op = q;
        end
      end
    endcase
  endfunction : apply_op
  function automatic math_unit_pkg::op_type op_of(input logic [5:0] ops,
                                                  input int k);
    op_of = math_unit_pkg::op_type'(ops[2*k +: 2]);
  endfunction : op_of
  // three-step priority evaluation, list of live terms collapses each step
  math_unit_pkg::result_type eval;
  always_comb
  begin
    wide_type t [4];
    logic [1:0] opi [3];
    logic [1:0] pr [3];
    int n;
    int pick;
    logic zd;
    wide_type v;
    pick = 0;
    v = '0;
    for (int i = 0; i < 4; i++)
      t[i] = wide_type'(opnd[i]);
    for (int i = 0; i < 3; i++)
    begin
      opi[i] = 2'(i);
      pr[i] = prio_ff[2*i +: 2];
    end
    n = 3;
    zd = 1'b0;
    for (int lvl = 2; lvl >= 0; lvl--)
    begin
      pick = 0;
      for (int i = 0; i < 3; i++)
        if (i < n && pr[i] == 2'(lvl))
          pick = i;
      if (op_of(ops_ff, int'(opi[pick])) == math_unit_pkg::OP_DIV && t[pick+1] == 0)
        zd = 1'b1;
      t[pick] = apply_op(op_of(ops_ff, int'(opi[pick])), t[pick], t[pick+1], lvl == 0);
      for (int i = 0; i < 3; i++)
      begin
        if (i > pick)
          t[i] = t[i+1];
        if (i >= pick && i < 2)
        begin
          opi[i] = opi[i+1];
          pr[i] = pr[i+1];
        end
      end
      // a repeated level leaves another level unmatched, and its pick stays on slot 0; distinct levels assumed
      n = n - 1;
    end
    v = t[0];
    eval.err.zero_div = zd;
    eval.err.overflow = 1'b0;
    if (zd || v > 64'sd32767)
    begin
      eval.value = `SAT_MAX;
      eval.err.overflow = !zd;
    end
    else if (v < -64'sd32768)
    begin
      eval.value = `SAT_MIN;
      eval.err.overflow = 1'b1;
    end
    else
      eval.value = 16'(v);
  end
  // evaluation once per clock while enabled
  wire signed [15:0] nxt_result = enable ? eval.value :
                                  (ctrl_ff[`CTRL_HOLD_BIT] ? result_ff : 16'sh0000);
  wire nxt_zdiv = enable ? eval.err.zero_div : zdiv_ff;
  wire nxt_ovf = enable ? eval.err.overflow : ovf_ff;
  // decimal places field is stored for display software only
  wire [1:0] dec_places = ctrl_ff[`CTRL_DEC_LSB +: 2];
  // write channel: take address and data in either order
  logic aw_held_ff;
  logic w_held_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire [11:0] wa = aw_take ? s_axi_awaddr : awaddr_ff;
  wire [31:0] wd = w_take ? s_axi_wdata : wdata_ff;
  wire [3:0] ws = w_take ? s_axi_wstrb : wstrb_ff;
  wire wr_go = (aw_take || aw_held_ff) && (w_take || w_held_ff);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      merge[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
  endfunction : merge
  wire wr_ctrl = wr_go && wa == `OFS_CTRL;
  wire wr_opsel = wr_go && wa == `OFS_OPSEL;
  wire wr_ops = wr_go && wa == `OFS_OPS;
  wire wr_prio = wr_go && wa == `OFS_PRIO;
  wire wr_istat = wr_go && wa == `OFS_IRQ_STAT;
  wire wr_imask = wr_go && wa == `OFS_IRQ_MASK;
  wire wr_const = wr_go && wa[11:4] == 8'h01;
  wire wr_known = wr_ctrl || wr_opsel || wr_ops || wr_prio || wr_istat || wr_imask
                  || wr_const || wa == `OFS_RESULT || wa == `OFS_STATUS;
  wire [31:0] wmerged = merge(32'h0000_0000, wd, ws);
  wire [31:0] ctrl_merged = merge(ctrl_ff, wd, ws);
  wire [31:0] const_merged = merge({16'h0000, const_ff[wa[3:2]]}, wd, ws);
  wire [`IRQ_BITS-1:0] irq_event = {nxt_ovf && enable, nxt_zdiv && enable};
  // set wins over a write-one clear in the same cycle
  wire [`IRQ_BITS-1:0] nxt_irq_stat = (irq_stat_ff & ~(wr_istat ? wmerged[`IRQ_BITS-1:0] :
                                      {`IRQ_BITS{1'b0}})) | irq_event;
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ctrl_ff <= `CTRL_RESET;
      opsel_ff <= 4'h0;
      ops_ff <= `OPS_RESET;
      prio_ff <= `PRIO_RESET;
      for (int i = 0; i < 4; i++)
        const_ff[i] <= 16'sh0000;
      irq_mask_ff <= 2'h0;
      irq_stat_ff <= 2'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= {29'h0, ctrl_merged[2:0]};
      if (wr_opsel)
        opsel_ff <= wmerged[3:0];
      if (wr_ops)
        ops_ff <= wmerged[5:0];
      if (wr_prio)
        prio_ff <= wmerged[5:0];
      if (wr_const)
        const_ff[wa[3:2]] <= const_merged[15:0];
      if (wr_imask)
        irq_mask_ff <= wmerged[`IRQ_BITS-1:0];
      irq_stat_ff <= nxt_irq_stat;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      result_ff <= 16'sh0000;
      zdiv_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end
    else
    begin
      result_ff <= nxt_result;
      zdiv_ff <= nxt_zdiv;
      ovf_ff <= nxt_ovf;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (aw_take)
        awaddr_ff <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      aw_held_ff <= wr_go ? 1'b0 : (aw_held_ff || aw_take);
      w_held_ff <= wr_go ? 1'b0 : (w_held_ff || w_take);
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // read decode
  wire [11:0] ra = s_axi_araddr;
  logic [31:0] rmux;
  logic rok;
  always_comb
  begin
    rok = 1'b1;
    unique case (ra)
      `OFS_CTRL: rmux = ctrl_ff;
      `OFS_OPSEL: rmux = {28'h0, opsel_ff};
      `OFS_OPS: rmux = {26'h0, ops_ff};
      `OFS_PRIO: rmux = {26'h0, prio_ff};
      `OFS_CONST0, `OFS_CONST1, `OFS_CONST2, `OFS_CONST3:
        rmux = {16'h0, const_ff[ra[3:2]]};
      `OFS_RESULT: rmux = {16'h0, result_ff};
      `OFS_STATUS: rmux = {28'h0, dec_places, ovf_ff, zdiv_ff};
      `OFS_IRQ_STAT: rmux = {30'h0, irq_stat_ff};
      `OFS_IRQ_MASK: rmux = {30'h0, irq_mask_ff};
      default:
      begin
        rmux = 32'h0000_0000;
        rok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rmux;
      s_axi_rresp <= rok ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  assign math_result = result_ff;
  assign zero_div_flag = zdiv_ff;
  assign overflow_flag = ovf_ff;
  assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule : four_operand_math_unit
`default_nettype wire

// file: dv/link_model.sv
/* other-block model: drives the four linked operands.
   assumes the mclk domain; values loaded by the bench. */
`timescale 1ns/100ps
`default_nettype none
module link_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [63:0] load_val,
  output logic signed [15:0] link_out [4]
);
  // a linked block updates once per scan, one edge after its own inputs
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      link_out[i] <= srst ? 16'h0000 : load_val[16*i+:16];
    end
  end
endmodule : link_model
`default_nettype wire

// file: dv/four_operand_math_unit_asserts.sv
/* checker: result, flag and bus handshake properties.
   assumes only the top ports; bound at the foot. */
`timescale 1ns/100ps
`default_nettype none
module math_unit_asserts (
  input wire logic mclk,
  input wire logic srst,
  input wire logic enable,
  input wire logic signed [15:0] math_result,
  input wire logic zero_div_flag,
  input wire logic overflow_flag,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
  property p_zdiv; $past(enable) && zero_div_flag |-> math_result == 16'sh7FFF; endproperty
  property p_ovf;
    $past(enable) && overflow_flag |-> math_result inside {16'sh7FFF, 16'sh8000};
  endproperty
  property p_excl; !(zero_div_flag && overflow_flag); endproperty
  property p_off; !enable |=> math_result == $past(math_result) || math_result == 0; endproperty
  property p_flag; !enable |=> $stable({zero_div_flag, overflow_flag}); endproperty
  property p_b; s_wr |=> s_axi_bvalid; endproperty
  property p_r; s_rd |=> s_axi_rvalid && !s_axi_arready; endproperty
  property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_zdiv: assert property (p_zdiv) else $error("zero divide not saturated");
  a_ovf: assert property (p_ovf) else $error("overflow not saturated");
  a_excl: assert property (p_excl) else $error("both flags set");
  a_off: assert property (p_off) else $error("disabled output moved");
  a_flag: assert property (p_flag) else $error("flags moved while disabled");
  a_b: assert property (p_b) else $error("write response late");
  a_r: assert property (p_r) else $error("read response late");
  a_rh: assert property (p_rh) else $error("read data dropped");
endmodule : math_unit_asserts
bind four_operand_math_unit math_unit_asserts chk (
  .mclk(mclk),
  .srst(srst),
  .enable(enable),
  .math_result(math_result),
  .zero_div_flag(zero_div_flag),
  .overflow_flag(overflow_flag),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata)
);
`default_nettype wire

// file: dv/four_operand_math_unit_tb.sv
/* bench: corner and random equations, bus and interrupt.
   assumes link model and checker compiled first. */
`timescale 1ns/100ps
`default_nettype none
module four_operand_math_unit_tb;
  logic mclk = 0, srst = 1, enable = 0, zero_div_flag, overflow_flag, irq;
  logic [63:0] load_val = '0;
  logic signed [15:0] link_operand [4];
  logic signed [15:0] math_result;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, rng = 32'h5039A689;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [17:0] e;
  int n_fail = 0, num_checks = 0;
  localparam logic [63:0] cv_t [8] = '{64'h0001_0003_0006_000C, 64'h0004_0001_0003_0002,
    64'h0001_0002_0019_0064, 64'h0000_0000_0000_0005, 64'h0000_0001_012C_012C,
    64'h0000_0001_012C_FED4, 64'h0000_0001_0002_0007, 64'h0000_0001_0002_FFF9};
  localparam logic [5:0] op_t [8] = '{6'h1C, 6'h08, 6'h0D, 6'h03, 6'h0A, 6'h0A, 6'h0B, 6'h0B};
  localparam logic [5:0] pr_t [8] = '{6'h09, 6'h24, 6'h12, 6'h06, 6'h06, 6'h06, 6'h24, 6'h24};
  localparam logic [5:0] perm [6] = '{6'h24, 6'h18, 6'h21, 6'h09, 6'h12, 6'h06};
  always #12.5 mclk = ~mclk;
  link_model lm (.mclk, .srst, .load_val, .link_out(link_operand));
  four_operand_math_unit uut (.*);
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd
  function automatic longint ar(input longint a, input longint b, input int op, input bit last,
    inout logic z);
    longint q;
    case (op)
      0: return a + b;
      1: return a - b;
      2: return a * b;
      default:
      begin
        if (b == 0)
        begin
          z = '1;
          return 0;
        end
        q = a / b;
        // only the last step rounds; earlier quotients truncate
        if (last && 2 * (a - q * b) * (a < 0 ? -1 : 1) >= b * (b < 0 ? -1 : 1))
          q += ((a < 0) != (b < 0)) ? -1 : 1;
        return q;
      end
    endcase
  endfunction : ar
  function automatic logic [17:0] calc(input logic [63:0] v, input logic [5:0] op,
    input logic [5:0] pr);
    longint x [4];
    int o [3], p [3], k, n;
    logic z;
    z = '0;
    n = 3;
    for (int i = 0; i < 4; i++) x[i] = $signed(v[16*i+:16]);
    for (int i = 0; i < 3; i++)
    begin
      o[i] = op[2*i+:2];
      p[i] = pr[2*i+:2];
    end
    for (int lv = 2; lv >= 0; lv--)
    begin
      k = 0;
      while (p[k] != lv) k++;
      x[k] = ar(x[k], x[k+1], o[k], lv == 0, z);
      for (int j = k; j < n - 1; j++)
      begin
        x[j+1] = x[j+2];
        o[j] = o[j+1];
        p[j] = p[j+1];
      end
      n--;
    end
    if (z) return {2'h2, 16'h7FFF};
    if (x[0] > 32767) return {2'h1, 16'h7FFF};
    if (x[0] < -32768) return {2'h1, 16'h8000};
    return {2'h0, x[0][15:0]};
  endfunction : calc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] dat, input logic [1:0] er);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
    end while (!s_axi_bvalid);
    s_axi_bready <= '0;
    chk(s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] rs);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= '0;
    end while (!s_axi_rvalid);
    s_axi_rready <= '0;
    dat = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : rd
  task automatic run(input logic [63:0] cv, input logic [63:0] lv, input logic [3:0] sel,
    input logic [5:0] op, input logic [5:0] pr);
    logic [63:0] v;
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h010 + 12'(4 * i), {16'h0000, cv[16*i+:16]}, 2'h0);
      v[16*i+:16] = sel[i] ? lv[16*i+:16] : cv[16*i+:16];
    end
    wr(12'h004, {28'h0, sel}, 2'h0);
    wr(12'h008, {26'h0, op}, 2'h0);
    wr(12'h00C, {26'h0, pr}, 2'h0);
    load_val <= lv;
    e = calc(v, op, pr);
    @(posedge mclk);
    enable <= '1;
    repeat (2) @(posedge mclk);
    enable <= '0;
    @(posedge mclk);
    #1;
    chk({zero_div_flag, overflow_flag, math_result}, e);
    rd(12'h020, d, r);
    chk(d[15:0], e[15:0]);
  endtask : run
  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial
  begin
    logic [31:0] w;
    repeat (2) @(posedge mclk);
    srst <= '0;
    wr(12'h000, 32'h0000_0007, 2'h0);
    for (int i = 0; i < 8; i++) run(cv_t[i], '0, 4'h0, op_t[i], pr_t[i]);
    for (int i = 0; i < 40; i++)
    begin
      w = rnd();
      run({rnd(), rnd()}, {rnd(), rnd()}, w[3:0], w[9:4], perm[w[31:16] % 6]);
    end
    wr(12'h02C, 32'h0, 2'h0);
    wr(12'h028, 32'h3, 2'h0);
    run(cv_t[3], '0, 4'h0, op_t[3], pr_t[3]);
    chk(irq, 32'h0);
    rd(12'h028, d, r);
    chk(d, 32'h1);
    rd(12'h024, d, r);
    chk(d[1:0], 32'h1);
    chk(d[3:2], 32'h3);
    wr(12'h02C, 32'h1, 2'h0);
    chk(irq, 32'h1);
    wr(12'h028, 32'h1, 2'h0);
    chk(irq, 32'h0);
    wr(12'h02C, 32'h2, 2'h0);
    run(cv_t[4], '0, 4'h0, op_t[4], pr_t[4]);
    chk(irq, 32'h1);
    rd(12'h028, d, r);
    chk(d, 32'h2);
    wr(12'h000, 32'h0, 2'h0);
    @(posedge mclk);
    #1;
    chk({zero_div_flag, overflow_flag, math_result}, 32'h0001_0000);
    wr(12'h100, 32'h5, 2'h2);
    rd(12'h100, d, r);
    chk(r, 32'h2);
    chk(d, 32'h0);
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
endmodule : four_operand_math_unit_tb
`default_nettype wire
